// ---- rtl/lbf_pkg.sv ----
// Package for the LED boost fault manager: states, timing constants.
// Assumes a single 25 MHz core clock.
package lbf_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ          = 25;
   localparam int RESET_HOLD_MS    = 16;
   localparam int RESET_HOLD_CYC   = RESET_HOLD_MS * 1000 * CLK_MHZ;
   localparam int UVLO_DEGLITCH_US = 50;
   localparam int UVLO_DEGLITCH_CYC = UVLO_DEGLITCH_US * CLK_MHZ;
   localparam int IOC_SHUTDOWN_NS  = 3000;
   localparam int CLK_PERIOD_NS    = 40;
   localparam int IOC_SHUTDOWN_CYC = IOC_SHUTDOWN_NS / CLK_PERIOD_NS;
   localparam int TMR_W            = 20;

   // ---------------------------------------------------------------
   // Supervisor states, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      LBF_OFF     = 5'h01,
      LBF_CHECK   = 5'h02,
      LBF_RUN     = 5'h04,
      LBF_SHORT   = 5'h08,
      LBF_LATCHED = 5'h10
   } lbf_state_t;
endpackage : lbf_pkg

// ---- rtl/lbf_low_timer.sv ----
// Counter that measures how long a level has stayed continuously active.
// Assumes the level is synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module lbf_low_timer #(
   parameter int LIMIT = 16,
   parameter int W     = 20
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic level,
   output logic      expired
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         exp_d;
   localparam logic [W-1:0] LAST = W'(LIMIT - 1);

   always_comb begin
      cnt_d = '0;
      exp_d = 1'b0;
      if (level) begin
         cnt_d = (cnt_q == LAST) ? cnt_q : cnt_q + W'(1);
         exp_d = (cnt_q == LAST);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q   <= '0;
         expired <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         expired <= exp_d;
      end
   end
endmodule : lbf_low_timer
`default_nettype wire

// ---- rtl/lbf_fault_mgr.sv ----
// Fault supervisor for a boost LED driver: switch limits, input
// overcurrent, undervoltage lockout and LED short-to-ground check.
// Assumes comparator inputs are already synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// [R1] A primary switch limit trip ends the on-time only, with no flag and no other output change.
// [R2] A secondary switch limit trip shuts the block down at once into a latched-off state.
// [R3] That trip opens the disconnect switch, drops sinks and boost, and raises the fault flag.
// [R4] The secondary latch clears only after the enable/dimming input stays low for 16 ms.
// [R5] An input overcurrent trip completes shutdown in under 3 us.
// [R6] After input overcurrent the fault flag is driven low and the block stays latched off.
// [R7] Input overcurrent removes the disconnect gate drive at once, also during startup.
// [R8] The input overcurrent latch clears only after the enable/dimming input is low for 16 ms.
// [R9] Lockout releases on the rise level and asserts only after 50 us below the fall level.
// [R10] An LED pin shorted to ground at first enable halts startup with disconnect on and flag set.
// [R11] The halted startup resumes by itself once the short is gone.
// [R12] Detectors that startup transients would trip are masked during startup.
// [R13] The fault flag is open drain: pulled low on fault, released otherwise.
// [R14] A lockout event clears every latched fault and turns all outputs off.
// [R15] The clear timer counts only while enable is continuously low and restarts otherwise.
module lbf_fault_mgr #(
   parameter int NUM_SINKS     = 6,
   parameter int RESET_HOLD    = lbf_pkg::RESET_HOLD_CYC,
   parameter int STARTUP_MASK  = 64
) (
   input  wire logic                 core_clk,
   input  wire logic                 reset_n,
   input  wire logic                 en_pwm,
   input  wire logic                 pwm_on_req,
   input  wire logic                 lockout_rise_ok,
   input  wire logic                 lockout_fall_low,
   input  wire logic                 primary_switch_trip,
   input  wire logic                 secondary_switch_trip,
   input  wire logic                 input_overcurrent_trip,
   input  wire logic [NUM_SINKS-1:0] led_pin_grounded,
   output logic                      boost_gate_en,
   output logic                      disconnect_pmos_on,
   output logic [NUM_SINKS-1:0]      sink_en,
   output logic                      fault_flag_o,
   output logic                      fault_flag_oe_n,
   output logic                      latched_fault
);
   localparam int UV_W = 12;
   localparam logic [UV_W-1:0] UV_LAST = UV_W'(lbf_pkg::UVLO_DEGLITCH_CYC);
   localparam logic [7:0]      SM_LAST = 8'(STARTUP_MASK);

   // ---------------------------------------------------------------
   // Lockout deglitch and enable-low clear timer
   // ---------------------------------------------------------------
   logic            uv_ok_q,  uv_ok_d;
   logic [UV_W-1:0] uv_cnt_q, uv_cnt_d;
   logic            clear_hit;

   always_comb begin
      uv_ok_d  = uv_ok_q;
      uv_cnt_d = '0;
      if (!uv_ok_q) begin
         uv_ok_d = lockout_rise_ok;                              // R9
      end else if (lockout_fall_low) begin
         uv_cnt_d = uv_cnt_q + UV_W'(1);
         if (uv_cnt_q == UV_LAST) begin
            uv_ok_d  = 1'b0;                                     // R9
            uv_cnt_d = '0;
         end
      end
   end

   lbf_low_timer #(.LIMIT(RESET_HOLD), .W(lbf_pkg::TMR_W)) u_clr (
      .clk     (core_clk),
      .reset_n (reset_n),
      .level   (!en_pwm),                                        // R15
      .expired (clear_hit)
   );

   // ---------------------------------------------------------------
   // Supervisor
   // ---------------------------------------------------------------
   lbf_pkg::lbf_state_t st_q, st_d;
   logic [7:0] sm_cnt_q, sm_cnt_d;
   logic       masked;
   logic       any_short;

   assign masked    = (sm_cnt_q != SM_LAST);
   assign any_short = |led_pin_grounded;

   always_comb begin
      st_d     = st_q;
      sm_cnt_d = sm_cnt_q;
      unique case (st_q)
         lbf_pkg::LBF_OFF: begin
            sm_cnt_d = '0;
            if (uv_ok_q && en_pwm && pwm_on_req)
               st_d = lbf_pkg::LBF_CHECK;
         end
         lbf_pkg::LBF_CHECK: begin
            st_d = any_short ? lbf_pkg::LBF_SHORT : lbf_pkg::LBF_RUN;  // R10
         end
         lbf_pkg::LBF_SHORT: begin
            if (!any_short) st_d = lbf_pkg::LBF_RUN;             // R11
         end
         lbf_pkg::LBF_RUN: begin
            if (masked) sm_cnt_d = sm_cnt_q + 8'h01;             // R12
            if (!en_pwm && clear_hit) st_d = lbf_pkg::LBF_OFF;
         end
         lbf_pkg::LBF_LATCHED: begin
            if (clear_hit) st_d = lbf_pkg::LBF_OFF;              // R4 R8
         end
         default: st_d = lbf_pkg::LBF_OFF;
      endcase
      // Input OC latches in every active state, startup included; secondary trip only in RUN once unmasked
      if (st_q != lbf_pkg::LBF_OFF && st_q != lbf_pkg::LBF_LATCHED) begin
         if (input_overcurrent_trip) st_d = lbf_pkg::LBF_LATCHED; // R5 R7
         if (secondary_switch_trip && !masked)
            st_d = lbf_pkg::LBF_LATCHED;                         // R2 R12
      end
      if (!uv_ok_q) st_d = lbf_pkg::LBF_OFF;                     // R14
   end

   // ---------------------------------------------------------------
   // Outputs, all registered
   // ---------------------------------------------------------------
   logic                 boost_d, disc_d, flag_d, latch_d;
   logic [NUM_SINKS-1:0] sink_d;

   always_comb begin
      boost_d = 1'b0;
      disc_d  = 1'b0;
      flag_d  = 1'b0;
      sink_d  = '0;
      latch_d = (st_d == lbf_pkg::LBF_LATCHED);
      unique case (st_d)
         lbf_pkg::LBF_OFF, lbf_pkg::LBF_LATCHED: flag_d = latch_d; // R3 R6
         lbf_pkg::LBF_CHECK: disc_d = 1'b1;
         lbf_pkg::LBF_SHORT: begin
            disc_d = 1'b1;                                       // R10
            flag_d = 1'b1;
         end
         lbf_pkg::LBF_RUN: begin
            disc_d  = 1'b1;
            sink_d  = {NUM_SINKS{pwm_on_req}};
            // Primary limit only chops this on-time
            boost_d = pwm_on_req && !primary_switch_trip;        // R1
         end
         default: ;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         uv_ok_q            <= 1'b0;
         uv_cnt_q           <= '0;
         st_q               <= lbf_pkg::LBF_OFF;
         sm_cnt_q           <= '0;
         boost_gate_en      <= 1'b0;
         disconnect_pmos_on <= 1'b0;
         sink_en            <= '0;
         fault_flag_o       <= 1'b0;
         fault_flag_oe_n    <= 1'b1;
         latched_fault      <= 1'b0;
      end else begin
         uv_ok_q            <= uv_ok_d;
         uv_cnt_q           <= uv_cnt_d;
         st_q               <= st_d;
         sm_cnt_q           <= sm_cnt_d;
         boost_gate_en      <= boost_d;
         disconnect_pmos_on <= disc_d;
         sink_en            <= sink_d;
         fault_flag_o       <= 1'b0;
         fault_flag_oe_n    <= !flag_d;                          // R13
         latched_fault      <= latch_d;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Outputs register the next state, so they agree with st_q in the same cycle
   a_ioc_disc_off: assert property (@(posedge core_clk) disable iff (!reset_n) // R7
      input_overcurrent_trip && disconnect_pmos_on && uv_ok_q
      |-> ##[1:2] !disconnect_pmos_on) else $error("disconnect not opened");
   a_ioc_fast: assert property (@(posedge core_clk) disable iff (!reset_n) // R5
      input_overcurrent_trip && boost_gate_en |-> ##[1:2] !boost_gate_en)
      else $error("ioc shutdown slow");
   a_sec_latch: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
      secondary_switch_trip && st_q == lbf_pkg::LBF_RUN && !masked && uv_ok_q
      |=> latched_fault && !fault_flag_oe_n && !disconnect_pmos_on && sink_en == '0)
      else $error("secondary trip not latched");
   a_sec_outputs: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
      latched_fault |-> !boost_gate_en && !disconnect_pmos_on && !fault_flag_oe_n)
      else $error("latched outputs wrong");
   a_latch_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // R4
      latched_fault && !clear_hit && uv_ok_q |=> latched_fault)
      else $error("latch dropped early");
   a_ioc_flag: assert property (@(posedge core_clk) disable iff (!reset_n) // R6
      st_q == lbf_pkg::LBF_LATCHED |-> !fault_flag_oe_n)
      else $error("flag not low");
   a_latch_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
      st_q == lbf_pkg::LBF_LATCHED && clear_hit && uv_ok_q |=> st_q == lbf_pkg::LBF_OFF)
      else $error("latch not cleared");
   a_uv_deglitch: assert property (@(posedge core_clk) disable iff (!reset_n) // R9
      uv_ok_q && !lockout_fall_low |=> uv_ok_q)
      else $error("lockout without dip");
   a_short_halt: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
      st_q == lbf_pkg::LBF_SHORT
      |-> sink_en == '0 && !boost_gate_en && disconnect_pmos_on && !fault_flag_oe_n)
      else $error("short halt outputs");
   a_primary_noflag: assert property (@(posedge core_clk) disable iff (!reset_n) // R1
      st_q == lbf_pkg::LBF_RUN && primary_switch_trip && !secondary_switch_trip
      && !input_overcurrent_trip && uv_ok_q && en_pwm |=> !boost_gate_en && disconnect_pmos_on
      && fault_flag_oe_n) else $error("primary trip misbehaves");
   a_uv_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // R14
      !uv_ok_q |=> st_q == lbf_pkg::LBF_OFF) else $error("lockout not off");
   a_clear_restart: assert property (@(posedge core_clk) disable iff (!reset_n) // R15
      en_pwm |=> !clear_hit) else $error("clear timer ran while enabled");
   c_latched: cover property (@(posedge core_clk) st_q == lbf_pkg::LBF_LATCHED);
   c_short:   cover property (@(posedge core_clk) st_q == lbf_pkg::LBF_SHORT);
   c_run:     cover property (@(posedge core_clk) boost_gate_en);
   c_lockout: cover property (@(posedge core_clk) uv_ok_q ##1 !uv_ok_q);
endmodule : lbf_fault_mgr
`default_nettype wire

// ---- tb/lbf_host_model.sv ----
// Host controller model: drives the enable/dimming pin, watches the fault line.
// Assumes a pull-up on the shared fault line and a single core clock.
`timescale 1ns/1ns
`default_nettype none
module lbf_host_model #(
   parameter int HOLD = 20
) (
   input  wire logic clk,
   input  wire logic run_req,
   input  wire logic recover,
   input  wire logic fault_line,
   output logic      en_pwm,
   output logic      pwm_on_req
);
   int   low_cnt  = 0;
   logic hold_low = 1'b0;
   // Recovery only starts on a reported fault; margin over the clear time
   // Sampled on the rising edge so the bench's falling-edge changes never race
   always @(posedge clk) begin
      if (recover && !fault_line && low_cnt == 0) begin
         low_cnt <= HOLD + 4;
      end else if (low_cnt > 0) begin
         low_cnt <= low_cnt - 1;
      end
   end
   // The pin itself moves on the falling edge, like every other input
   always @(negedge clk) hold_low <= (low_cnt != 0);
   assign en_pwm     = run_req && !hold_low;
   assign pwm_on_req = en_pwm;
endmodule : lbf_host_model
`default_nettype wire

// ---- tb/lbf_fault_mgr_bench.sv ----
// Self-checking bench for the fault supervisor with a host model.
// Assumes inputs change on the falling edge of a 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module lbf_fault_mgr_bench;
   localparam int HOLD = 20;
   logic        core_clk = 1'b0;
   logic        reset_n  = 1'b0;
   logic        run_req  = 1'b0;
   logic        recover  = 1'b0;
   logic        rise_ok  = 1'b1;
   logic        fall_low = 1'b0;
   logic        p_trip   = 1'b0;
   logic        s_trip   = 1'b0;
   logic        oc_trip  = 1'b0;
   logic [5:0]  grounded = 6'h00;
   logic        en_pwm, pwm_on_req, boost, disc, flag_o, flag_oe_n, latched;
   logic [5:0]  sinks;
   logic [31:0] rng = 32'h57A82BAC;
   int          num_errors = 0;
   int          tests_run  = 0;
   int          i;
   wire         fault_line = flag_oe_n ? 1'b1 : flag_o;

   always #20 core_clk = ~core_clk;

   lbf_host_model #(.HOLD(HOLD)) lbf_host_model_i (.clk(core_clk), .run_req(run_req),
      .recover(recover), .fault_line(fault_line), .en_pwm(en_pwm), .pwm_on_req(pwm_on_req));

   lbf_fault_mgr #(.NUM_SINKS(6), .RESET_HOLD(HOLD)) lbf_fault_mgr_i (.core_clk(core_clk),
      .reset_n(reset_n), .en_pwm(en_pwm), .pwm_on_req(pwm_on_req), .lockout_rise_ok(rise_ok),
      .lockout_fall_low(fall_low), .primary_switch_trip(p_trip),
      .secondary_switch_trip(s_trip), .input_overcurrent_trip(oc_trip),
      .led_pin_grounded(grounded), .boost_gate_en(boost), .disconnect_pmos_on(disc),
      .sink_en(sinks), .fault_flag_o(flag_o), .fault_flag_oe_n(flag_oe_n),
      .latched_fault(latched));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   function automatic logic [5:0] exp_sinks(input logic on);
      return on ? 6'h3F : 6'h00;
   endfunction : exp_sinks

   task automatic test_done();
      $display("Checks %0d, errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done

   task automatic chk_bit(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s: got %b", $time, what, got);
      end
   endtask : chk_bit

   // Flag f set means the shared line must read low
   task automatic chk_out(input logic b, input logic d, input logic s, input logic f,
                          input string what);
      tests_run++;
      if (boost !== b || disc !== d || sinks !== exp_sinks(s) || fault_line !== !f) begin
         num_errors++;
         $display("[ERR] %0t %s: %b %b %h %b", $time, what, boost, disc, sinks, fault_line);
      end
      $display("step %s done", what);
   endtask : chk_out

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc

   task automatic wait_latch(input int bound);
      for (i = 0; i < bound && latched !== 1'b1; i++) cyc(1);
      if (latched !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t latch never set", $time);
         test_done();
      end
   endtask : wait_latch

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      cyc(5);
      reset_n = 1'b1;
      run_req = 1'b1;
      cyc(3);
      chk_out(1, 1, 1, 0, "startup");
      s_trip = 1'b1;
      cyc(1);
      s_trip = 1'b0;
      cyc(2);
      chk_bit(latched, 1'b0, "masked trip");
      repeat (6) begin
         rng = xs(rng);
         cyc(2 + int'(rng[2:0]));
         p_trip = 1'b1;
         cyc(1);
         p_trip = 1'b0;
         chk_bit(boost, 1'b0, "on-time cut");
         chk_out(0, 1, 1, 0, "primary");
         cyc(2);
         chk_out(1, 1, 1, 0, "next cycle");
      end
      rng = xs(rng);
      cyc(70 + int'(rng[3:0]));
      s_trip = 1'b1;
      wait_latch(2);
      s_trip = 1'b0;
      chk_out(0, 0, 0, 1, "secondary");
      chk_bit(flag_o, 1'b0, "drain level");
      run_req = 1'b0;
      cyc(HOLD - 5);
      run_req = 1'b1;
      cyc(2);
      chk_bit(latched, 1'b1, "short low");
      recover = 1'b1;
      cyc(1);
      recover = 1'b0;
      cyc(HOLD + 10);
      chk_out(1, 1, 1, 0, "secondary cleared");
      run_req = 1'b0;
      cyc(HOLD + 4);
      run_req = 1'b1;
      rng = xs(rng);
      cyc(1 + int'(rng[0]));
      oc_trip = 1'b1;
      for (i = 0; i < lbf_pkg::IOC_SHUTDOWN_CYC && disc !== 1'b0; i++) cyc(1);
      chk_bit(disc, 1'b0, "disconnect off");
      wait_latch(2);
      oc_trip = 1'b0;
      chk_out(0, 0, 0, 1, "input overcurrent");
      rise_ok = 1'b0;
      fall_low = 1'b1;
      cyc(1000);
      chk_bit(latched, 1'b1, "short dip");
      cyc(300);
      chk_bit(latched, 1'b0, "lockout clear");
      chk_out(0, 0, 0, 0, "lockout");
      rise_ok = 1'b1;
      fall_low = 1'b0;
      cyc(4);
      chk_out(1, 1, 1, 0, "lockout release");
      recover = 1'b1;
      oc_trip = 1'b1;
      wait_latch(4);
      oc_trip = 1'b0;
      cyc(HOLD + 10);
      recover = 1'b0;
      chk_out(1, 1, 1, 0, "overcurrent cleared");
      run_req = 1'b0;
      cyc(HOLD + 4);
      rng = xs(rng);
      grounded = rng[5:0] | 6'h01;
      run_req = 1'b1;
      cyc(4);
      chk_out(0, 1, 0, 1, "grounded pin");
      grounded = 6'h00;
      cyc(4);
      chk_out(1, 1, 1, 0, "short removed");
      test_done();
   end
endmodule : lbf_fault_mgr_bench
`default_nettype wire
